// ==== design/memory_protection_unit.sv ====
`timescale 1ns/10ps
// What this block does
// - Two full protection sets, index 0 and 1
// - Status word field picks active set
// - Data checked on data part, fetch on code
// - Data part has four ranges
// - Code part has two ranges
// - Bound pairs plus one mode register per part
// - Violations raise a trap to CPU
// - Violations also signal the debug unit
module memory_protection_unit
    import mpu_pkg::*;
#(
    parameter int NUM_DR = DATA_RANGES,
    parameter int NUM_CR = CODE_RANGES
) (
    input wire logic clk,
    input wire logic reset,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Active set field of the processor status word
    input wire logic active_protection_set_select,
    // Data access request
    input wire logic data_req,
    input wire logic data_write,
    input wire logic [31:0] data_addr,
    output logic data_ack,
    output logic data_blocked,
    // Instruction fetch request
    input wire logic fetch_req,
    input wire logic [31:0] fetch_addr,
    output logic fetch_ack,
    output logic fetch_blocked,
    // Trap, debug and interrupt outputs
    output logic trap_handler_routine,
    output logic debug_violation,
    output logic irq
);
    // Bound registers live in flops so all ranges compare in parallel
    logic [31:0] bounds [BOUND_WORDS];
    logic [31:0] data_mode [NUM_SETS];
    logic [31:0] code_mode [NUM_SETS];
    logic [1:0] status;
    logic [1:0] mask;
    logic [31:0] fault_addr;
    logic [31:0] ram_rdata;
    chk_state_t state;
    chk_state_t next_state;
    // Latched request
    logic req_is_fetch;
    logic req_write;
    logic [31:0] req_addr;
    logic req_set;

    // APB decode
    // First access cycle: bound read data already stands in the ram register
    wire apb_first = psel && penable && !pready;
    wire apb_access = psel && penable;
    wire apb_wr = apb_access && pwrite && pready;
    wire is_bound = (paddr >= OFS_BOUNDS) && (paddr < OFS_BOUNDS + 12'(BOUND_WORDS * 4));
    wire [4:0] bound_idx = 5'((paddr - OFS_BOUNDS) >> 2);
    wire is_ctrl = (paddr == OFS_CONTROL);
    wire is_stat = (paddr == OFS_STATUS);
    wire is_mask = (paddr == OFS_MASK);
    wire is_fadr = (paddr == OFS_FAULT_ADDR);
    wire is_dm0 = (paddr == OFS_DMODE0);
    wire is_cm0 = (paddr == OFS_CMODE0);
    wire is_dm1 = (paddr == OFS_DMODE1);
    wire is_cm1 = (paddr == OFS_CMODE1);
    // Any decoded offset; the rest are refused
    wire mapped = is_bound || is_ctrl || is_stat || is_mask || is_fadr
        || is_dm0 || is_cm0 || is_dm1 || is_cm1;

    // Mode grant bit for a range and access kind
    function automatic logic mode_bit(input logic [31:0] m, input int r, input int k);
        mode_bit = m[r*MODE_STRIDE + k];
    endfunction : mode_bit

    // Read copy of bounds for software, one-cycle latency
    mpu_bound_ram #(.DEPTH(BOUND_WORDS), .AW(5)) u_ram (
        .clk(clk),
        .we(apb_wr && is_bound),
        .waddr(bound_idx),
        .wdata(pwdata),
        .raddr(bound_idx),
        .rdata(ram_rdata)
    );

    // Bound and mode registers per set and part
    always_ff @(posedge clk) begin
        if (reset) begin
            // Everything blocked after reset
            for (int i = 0; i < BOUND_WORDS; i++) begin
                bounds[i] <= 32'h0000_0000;
            end
            for (int s = 0; s < NUM_SETS; s++) begin
                data_mode[s] <= MODE_RESET;
                code_mode[s] <= MODE_RESET;
            end
        end else if (apb_wr) begin
            // Software write of a bound word
            if (is_bound) begin
                bounds[bound_idx] <= pwdata;
            end
            if (is_dm0) data_mode[0] <= pwdata;
            if (is_cm0) code_mode[0] <= pwdata;
            if (is_dm1) data_mode[1] <= pwdata;
            if (is_cm1) code_mode[1] <= pwdata;
        end
    end

    // Active set part: lower/upper bounds and grants
    logic [NUM_DR*32-1:0] d_lo, d_hi;
    logic [NUM_CR*32-1:0] c_lo, c_hi;
    logic [NUM_DR-1:0] d_grant, d_hit;
    logic [NUM_CR-1:0] c_grant, c_hit;
    genvar g;
    // One slice per range of the latched set
    generate
        for (g = 0; g < NUM_DR; g++) begin : g_d
            // Data ranges of the latched set
            assign d_lo[g*32 +: 32] = bounds[int'(req_set)*BOUNDS_PER_SET + g*2];
            assign d_hi[g*32 +: 32] = bounds[int'(req_set)*BOUNDS_PER_SET + g*2 + 1];
            assign d_grant[g] = mode_bit(data_mode[req_set], g,
                req_write ? MODE_WR : MODE_RD);
        end
        for (g = 0; g < NUM_CR; g++) begin : g_c
            // Code ranges follow the data ranges
            assign c_lo[g*32 +: 32] =
                bounds[int'(req_set)*BOUNDS_PER_SET + NUM_DR*2 + g*2];
            assign c_hi[g*32 +: 32] =
                bounds[int'(req_set)*BOUNDS_PER_SET + NUM_DR*2 + g*2 + 1];
            assign c_grant[g] = mode_bit(code_mode[req_set], g, MODE_EX);
        end
    endgenerate

    mpu_range_check #(.N(NUM_DR)) u_dchk (
        .addr(req_addr),
        .lower(d_lo),
        .upper(d_hi),
        .grant(d_grant),
        .hit(d_hit)
    );
    mpu_range_check #(.N(NUM_CR)) u_cchk (
        .addr(req_addr),
        .lower(c_lo),
        .upper(c_hi),
        .grant(c_grant),
        .hit(c_hit)
    );

    // Legal when any granting range contains the address
    wire legal = req_is_fetch ? (|c_hit) : (|d_hit);
    wire violation = (state == CHK_EVAL) && !legal;

    // Checker sequencing
    always_comb begin
        next_state = state;
        case (state)
            // Wait for a request
            CHK_IDLE: if (data_req || fetch_req) next_state = CHK_EVAL;
            // Compare cycle
            CHK_EVAL: next_state = CHK_ANSWER;
            // Answer cycle, requests ignored
            CHK_ANSWER: next_state = CHK_IDLE;
            // Illegal code
            default: next_state = CHK_IDLE;
        endcase
    end

    // State and request capture; data takes priority over fetch
    always_ff @(posedge clk) begin
        if (reset) begin
            state <= CHK_IDLE;
            req_is_fetch <= 1'b0;
            req_write <= 1'b0;
            req_addr <= 32'h0000_0000;
            req_set <= 1'b0;
        end else begin
            // Advance the checker
            state <= next_state;
            // Take a request only when idle
            if (state == CHK_IDLE && (data_req || fetch_req)) begin
                req_is_fetch <= !data_req;
                req_write <= data_req && data_write;
                req_addr <= data_req ? data_addr : fetch_addr;
                req_set <= active_protection_set_select;
            end
        end
    end

    // Answers, trap and debug pulses
    always_ff @(posedge clk) begin
        if (reset) begin
            data_ack <= 1'b0;
            data_blocked <= 1'b0;
            fetch_ack <= 1'b0;
            fetch_blocked <= 1'b0;
            trap_handler_routine <= 1'b0;
            debug_violation <= 1'b0;
        end else begin
            // Answers stand one cycle, after the compare cycle
            data_ack <= (state == CHK_EVAL) && !req_is_fetch;
            fetch_ack <= (state == CHK_EVAL) && req_is_fetch;
            data_blocked <= violation && !req_is_fetch;
            fetch_blocked <= violation && req_is_fetch;
            trap_handler_routine <= violation;
            debug_violation <= violation;
        end
    end

    // Sticky status, set wins over write-one clear; fault address capture
    wire [1:0] ev = {violation && req_is_fetch, violation && !req_is_fetch};
    always_ff @(posedge clk) begin
        if (reset) begin
            status <= 2'h0;
            mask <= MASK_RESET;
            fault_addr <= 32'h0000_0000;
            irq <= 1'b0;
        end else begin
            // Write one clears, a new event wins
            status <= (status & ~((apb_wr && is_stat) ? pwdata[1:0] : 2'h0)) | ev;
            // Mask written by software
            if (apb_wr && is_mask) mask <= pwdata[1:0];
            // Address of the latest blocked access
            if (violation) fault_addr <= req_addr;
            // Level interrupt from the next status value
            irq <= |(((status & ~((apb_wr && is_stat) ? pwdata[1:0] : 2'h0)) | ev) & mask);
        end
    end

    // APB: two-cycle access so bound reads come from the ram register
    wire [31:0] reg_rd = is_ctrl ? {31'h0, active_protection_set_select}
        : is_stat ? {30'h0, status}
        : is_mask ? {30'h0, mask}
        : is_fadr ? fault_addr
        : is_dm0 ? data_mode[0]
        : is_cm0 ? code_mode[0]
        : is_dm1 ? data_mode[1]
        : is_cm1 ? code_mode[1]
        : 32'h0000_0000;
    always_ff @(posedge clk) begin
        if (reset) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            // Answer in the second access cycle, one cycle wide
            pready <= apb_first;
            // Unmapped offsets are refused alongside ready
            pslverr <= apb_first && !mapped;
            // Read data loaded one edge before it is sampled
            if (apb_first) prdata <= is_bound ? ram_rdata : reg_rd;
        end
    end

    // Checks
    AST_TRAP_ON_BLOCK: assert property (@(posedge clk) disable iff (reset)
        (data_blocked || fetch_blocked) |-> trap_handler_routine)
        else $error("blocked access without trap");
    AST_DEBUG_WITH_TRAP: assert property (@(posedge clk) disable iff (reset)
        trap_handler_routine == debug_violation)
        else $error("debug line differs from trap");
    AST_ACK_LATENCY: assert property (@(posedge clk) disable iff (reset)
        (state == CHK_IDLE && data_req) |-> ##2 data_ack)
        else $error("data ack not two cycles after request");
    AST_FETCH_KIND: assert property (@(posedge clk) disable iff (reset)
        (state == CHK_IDLE && fetch_req && !data_req) |-> ##2 (fetch_ack && !data_ack))
        else $error("fetch answered on wrong path");
    AST_LEGAL_PASS: assert property (@(posedge clk) disable iff (reset)
        (state == CHK_EVAL && legal) |=> !trap_handler_routine)
        else $error("legal access trapped");
    AST_SET_LATCH: assert property (@(posedge clk) disable iff (reset)
        (state == CHK_IDLE && (data_req || fetch_req)) |=>
        req_set == $past(active_protection_set_select))
        else $error("active set not captured");
    AST_NO_GRANT_BLOCK: assert property (@(posedge clk) disable iff (reset)
        (state == CHK_EVAL && !req_is_fetch && d_grant == '0) |=> data_blocked)
        else $error("data access passed with no grant");
    AST_CODE_NO_GRANT: assert property (@(posedge clk) disable iff (reset)
        (state == CHK_EVAL && req_is_fetch && c_grant == '0) |=> fetch_blocked)
        else $error("fetch passed with no grant");
    AST_MODE_WRITE: assert property (@(posedge clk) disable iff (reset)
        (apb_wr && is_dm1) |=> data_mode[1] == $past(pwdata))
        else $error("mode register not written");
    AST_STATUS_STICKY: assert property (@(posedge clk) disable iff (reset)
        violation |=> status != 2'h0)
        else $error("violation not recorded");
    AST_ACK_PULSE: assert property (@(posedge clk) disable iff (reset)
        (data_ack || fetch_ack) |=> !(data_ack || fetch_ack))
        else $error("answer wider than one cycle");
    AST_FAULT_ADDR: assert property (@(posedge clk) disable iff (reset)
        violation |=> fault_addr == $past(req_addr))
        else $error("fault address not captured");
    COV_DATA_BLOCK: cover property (@(posedge clk) data_blocked);
    COV_FETCH_BLOCK: cover property (@(posedge clk) fetch_blocked);
    COV_SET1_PASS: cover property (@(posedge clk) data_ack && !data_blocked && req_set);
    COV_IRQ: cover property (@(posedge clk) irq);
endmodule : memory_protection_unit

// ==== design/mpu_pkg.sv ====
package mpu_pkg;
    // Sets and ranges
    localparam int NUM_SETS = 2;
    localparam int DATA_RANGES = 4;
    localparam int CODE_RANGES = 2;
    // Register offsets (byte addresses)
    localparam logic [11:0] OFS_CONTROL = 12'h000;
    localparam logic [11:0] OFS_STATUS = 12'h004;
    localparam logic [11:0] OFS_MASK = 12'h008;
    localparam logic [11:0] OFS_FAULT_ADDR = 12'h00C;
    localparam logic [11:0] OFS_DMODE0 = 12'h010;
    localparam logic [11:0] OFS_CMODE0 = 12'h014;
    localparam logic [11:0] OFS_DMODE1 = 12'h018;
    localparam logic [11:0] OFS_CMODE1 = 12'h01C;
    localparam logic [11:0] OFS_BOUNDS = 12'h100;
    // Bound table: set*12 + range*2 + (0 lower,1 upper); code ranges follow data
    localparam int BOUNDS_PER_SET = 12;
    localparam int BOUND_WORDS = 24;
    // Mode field layout per range: bit0 read, bit1 write, bit2 execute, nibble each
    localparam int MODE_RD = 0;
    localparam int MODE_WR = 1;
    localparam int MODE_EX = 2;
    localparam int MODE_STRIDE = 4;
    // Status bit positions
    localparam int ST_DATA_FAULT = 0;
    localparam int ST_CODE_FAULT = 1;
    // Reset values
    localparam logic [31:0] MODE_RESET = 32'h0000_0000;
    localparam logic [1:0] MASK_RESET = 2'h0;
    // Checker states, one-hot
    typedef enum logic [2:0] {
        CHK_IDLE = 3'b001,
        CHK_EVAL = 3'b010,
        CHK_ANSWER = 3'b100
    } chk_state_t;
endpackage : mpu_pkg

// ==== design/mpu_bound_ram.sv ====
`timescale 1ns/10ps
// Boundary register storage, one write port, registered read port
module mpu_bound_ram #(
    parameter int DEPTH = 24,
    parameter int AW = 5
) (
    input wire logic clk,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [31:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [31:0] rdata
);
    // Storage words
    logic [31:0] mem [DEPTH];

    // Write and registered read
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule : mpu_bound_ram

// ==== design/mpu_range_check.sv ====
`timescale 1ns/10ps
// Parallel compare of an address against N bound pairs
module mpu_range_check #(
    parameter int N = 4
) (
    input wire logic [31:0] addr,
    input wire logic [N*32-1:0] lower,
    input wire logic [N*32-1:0] upper,
    input wire logic [N-1:0] grant,
    output logic [N-1:0] hit
);
    // Lower bound inclusive, upper bound exclusive
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_rng
            assign hit[g] = grant[g] && (addr >= lower[g*32 +: 32])
                && (addr < upper[g*32 +: 32]);
        end
    endgenerate
endmodule : mpu_range_check

// ==== testbench/mpu_cpu_model.sv ====
`timescale 1ns/10ps
// CPU side: one request at a time, held until it is answered
module mpu_cpu_model (
    input wire logic clk,
    output logic data_req,
    output logic data_write,
    output logic [31:0] data_addr,
    output logic fetch_req,
    output logic [31:0] fetch_addr,
    input wire logic data_ack,
    input wire logic data_blocked,
    input wire logic fetch_ack,
    input wire logic fetch_blocked,
    input wire logic trap_handler_routine,
    input wire logic debug_violation
);
    // Idle request lines
    initial begin
        data_req = 1'b0;
        data_write = 1'b0;
        data_addr = 32'h0;
        fetch_req = 1'b0;
        fetch_addr = 32'h0;
    end
    // One transfer; released lines show the inverse of the last value
    task automatic access(input logic c, input logic wr, input logic [31:0] a,
                          output logic b, output logic t, output logic g);
        int n;
        n = 0;
        @(posedge clk);
        data_req <= !c;
        data_write <= wr;
        data_addr <= a;
        fetch_req <= c;
        fetch_addr <= a;
        // Hold until the answer, bounded
        do begin
            @(posedge clk);
            n++;
        end while ((c ? fetch_ack : data_ack) !== 1'b1 && n < 20);
        b = (n < 20) ? (c ? fetch_blocked : data_blocked) : 1'bx;
        t = trap_handler_routine;
        g = debug_violation;
        data_req <= 1'b0;
        fetch_req <= 1'b0;
        data_write <= !wr;
        data_addr <= ~a;
        fetch_addr <= ~a;
    endtask : access
endmodule : mpu_cpu_model

// ==== testbench/tb.sv ====
`timescale 1ns/10ps
// Self-checking bench with a reference model of the protection sets
module tb;
    import mpu_pkg::*;
    logic clk, reset, psel, penable, pwrite, sel_set, pready, pslverr, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, data_addr, fetch_addr;
    logic data_req, data_write, data_ack, data_blocked;
    logic fetch_req, fetch_ack, fetch_blocked, trap, dbg;
    int n_fail = 0;
    int n_checks = 0;
    logic [15:0] lfsr_q = 16'h971E; // Random source state
    logic [31:0] lo_m [2][6]; // Model bounds, code ranges at 4 and 5
    logic [31:0] hi_m [2][6];
    logic [31:0] md_m [2][2]; // Model modes, [set][code]
    logic [1:0] st_m = 2'h0; // Model status
    logic [1:0] mk_m = 2'h0; // Model mask
    logic [31:0] fault_m = 32'h0; // Model fault address

    memory_protection_unit dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .active_protection_set_select(sel_set), .data_req(data_req),
        .data_write(data_write), .data_addr(data_addr), .data_ack(data_ack),
        .data_blocked(data_blocked), .fetch_req(fetch_req), .fetch_addr(fetch_addr),
        .fetch_ack(fetch_ack), .fetch_blocked(fetch_blocked),
        .trap_handler_routine(trap), .debug_violation(dbg), .irq(irq));
    mpu_cpu_model cpu (.clk(clk), .data_req(data_req), .data_write(data_write),
        .data_addr(data_addr), .fetch_req(fetch_req), .fetch_addr(fetch_addr),
        .data_ack(data_ack), .data_blocked(data_blocked), .fetch_ack(fetch_ack),
        .fetch_blocked(fetch_blocked), .trap_handler_routine(trap), .debug_violation(dbg));

    // Shift register random source
    function automatic logic [15:0] rnd();
        lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
        return lfsr_q;
    endfunction : rnd
    // Legal if some granting range of the active part holds the address
    function automatic logic legal(int s, int c, logic wr, logic [31:0] a);
        int b;
        legal = 1'b0;
        b = c ? MODE_EX : (wr ? MODE_WR : MODE_RD);
        for (int r = 0; r < (c ? 2 : 4); r++) begin
            if (a >= lo_m[s][c*4+r] && a < hi_m[s][c*4+r] && md_m[s][c][r*MODE_STRIDE+b])
                legal = 1'b1;
        end
    endfunction : legal
    // Compare a word
    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_word
    // Compare a flag
    task automatic check_flag(input logic got, input logic exp);
        check_word({31'h0, got}, {31'h0, exp});
    endtask : check_flag
    // One bus transfer, held until pready
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Register write
    task automatic reg_wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask : reg_wr
    // Register read and compare
    task automatic reg_chk(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        check_word(r, exp);
        check_flag(e, 1'b0);
    endtask : reg_chk
    // One CPU access compared with the model
    task automatic access(input logic s, input logic c, input logic wr, input logic [31:0] a);
        logic b, t, g, x;
        @(posedge clk);
        sel_set <= s;
        x = !legal(s, c, wr, a);
        cpu.access(c, wr, a, b, t, g);
        check_flag(b, x);
        check_flag(t, x);
        check_flag(g, x);
        if (x) begin
            st_m[c] = 1'b1;
            fault_m = a;
        end
    endtask : access
    // Verdict
    task automatic end_sim();
        if (n_fail == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_sim

    // Clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Watchdog
    initial begin
        repeat (60000) @(posedge clk);
        n_fail++;
        end_sim();
    end
    // Main sequence
    initial begin
        logic [31:0] r;
        logic e;
        logic [15:0] x;
        logic [11:0] ba;
        int rr;
        reset = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        sel_set = 1'b0;
        lo_m = '{default: 32'h0};
        hi_m = '{default: 32'h0};
        md_m = '{default: 32'h0};
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        // Reset values, refused address, all blocked
        reg_chk(OFS_DMODE0, MODE_RESET);
        reg_chk(OFS_CMODE1, MODE_RESET);
        apb(1'b1, 12'hFF0, 32'hFFFF_FFFF, r, e);
        check_flag(e, 1'b1);
        apb(1'b0, 12'hFF0, 32'h0, r, e);
        check_word(r, 32'h0);
        check_flag(e, 1'b1);
        access(1'b1, 1'b1, 1'b0, 32'h0);
        // Program both sets and read back
        for (int s = 0; s < NUM_SETS; s++) begin
            for (int g = 0; g < 6; g++) begin
                lo_m[s][g] = 32'h1_0000 * (g + 1) + 32'h40 * s + 32'(rnd() % 16'h100);
                hi_m[s][g] = lo_m[s][g] + 32'h80;
                ba = 12'(OFS_BOUNDS + 4 * (s * BOUNDS_PER_SET + g * 2));
                reg_wr(ba, lo_m[s][g]);
                reg_wr(ba + 12'h4, hi_m[s][g]);
                reg_chk(ba + 12'h4, hi_m[s][g]);
            end
            md_m[s][0] = {16'h0, rnd()} & 32'h0000_7777;
            md_m[s][1] = {16'h0, rnd()} & 32'h0000_0077;
            reg_wr(s ? OFS_DMODE1 : OFS_DMODE0, md_m[s][0]);
            reg_wr(s ? OFS_CMODE1 : OFS_CMODE0, md_m[s][1]);
            reg_chk(s ? OFS_DMODE1 : OFS_DMODE0, md_m[s][0]);
            reg_chk(s ? OFS_CMODE1 : OFS_CMODE0, md_m[s][1]);
        end
        // Random accesses around range edges, both sets and parts
        for (int i = 0; i < 300; i++) begin
            x = rnd();
            rr = x[2] ? 4 + x[3] : x[4:3];
            access(x[0], x[2], x[1], lo_m[x[0]][rr] + 32'(rnd() % 16'h84) - 32'h2);
            reg_chk(OFS_CONTROL, {31'h0, x[0]});
            reg_chk(OFS_STATUS, {30'h0, st_m});
            reg_chk(OFS_FAULT_ADDR, fault_m);
            check_flag(irq, |(st_m & mk_m));
            mk_m = x[7:6];
            reg_wr(OFS_MASK, {30'h0, mk_m});
            if (x[5]) begin
                reg_wr(OFS_STATUS, {30'h0, x[9:8]});
                st_m = st_m & ~x[9:8];
            end
            reg_chk(OFS_MASK, {30'h0, mk_m});
            check_flag(irq, |(st_m & mk_m));
        end
        end_sim();
    end
endmodule : tb
